//--- sim/link_rx_model.sv
`timescale 1ns/100ps
module link_rx_model #(
  parameter int UP_DELAY = 6
) (
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  input  wire serial_link_regs_pkg::link_cfg_type link_cfg,
  input  wire logic                               sysref_req,
  input  wire logic                               realign_req,
  input  wire logic                               mode_8b10b,
  output serial_link_regs_pkg::link_status_type   link_st,
  output logic                                    sync_pin_n
);
  logic [7:0] wait_q, wait_d;
  logic [1:0] slot_q, slot_d;
  logic       up_q, up_d;

  // ----------------------------------------
  // Lock after a delay, slot every 4 cycles
  // ----------------------------------------
  always_comb begin
    wait_d = link_cfg.link_enable ? wait_q + {7'h00, wait_q != 8'hFF} : 8'h00;
    up_d   = link_cfg.link_enable && (wait_q >= 8'(UP_DELAY));
    slot_d = up_q ? slot_q + 2'h1 : 2'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_q <= 8'h00;
      slot_q <= 2'h0;
      up_q   <= 1'b0;
    end else begin
      wait_q <= wait_d;
      slot_q <= slot_d;
      up_q   <= up_d;
    end
  end

  // Sync held asserted until locked, as a real receiver does
  assign sync_pin_n = up_q;
  assign link_st = '{link_up: up_q, sysref_realign: realign_req, sysref_event: sysref_req,
                     frame_end_slot: up_q && (slot_q == 2'h3), eight_b_ten_b_mode: mode_8b10b};
endmodule

//--- sim/test_serial_link_param_status_regs.sv
`timescale 1ns/100ps
`include "serial_link_regs_cfg.svh"
module test_serial_link_param_status_regs;
  localparam int LANES = 7;
  localparam int CONVS = 4;
  typedef struct packed {
    logic [11:0] idx;
    logic [7:0]  wval;
    logic [7:0]  rval;
    logic [1:0]  resp;
  } row_type;
  logic                                  aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                                  arvalid, arready, rvalid, rready, irq, exp_ins;
  logic                                  sync_pin_n, spll_lock_pin, cpll_lock_pin, sysref_req, realign_req, mode;
  logic [15:0]                           awaddr, araddr;
  logic [31:0]                           wdata, rdata;
  logic [3:0]                            wstrb;
  logic [1:0]                            bresp, rresp;
  serial_link_regs_pkg::link_status_type link_st;
  serial_link_regs_pkg::link_cfg_type    link_cfg;
  serial_link_regs_pkg::chan_cfg_type    chan_cfg;
  int                                    num_errors, tests_run, n;
  logic [7:0]                            d;
  logic [1:0]                            rs;
  row_type rows [0:6] = '{'{12'h206, 8'hFF, 8'hFF, 2'h0}, '{12'h206, 8'h5A, 8'h5A, 2'h0},
                          '{12'h207, 8'hFF, 8'h03, 2'h0}, '{12'h207, 8'h01, 8'h01, 2'h0},
                          '{12'h209, 8'hFF, 8'h07, 2'h0}, '{12'h209, 8'h03, 8'h03, 2'h0},
                          '{12'h2FF, 8'h12, 8'h00, 2'h2}};
  logic [7:0]  kchar [0:3] = '{`EOF_K28_7, `EOF_K28_1, `EOF_K28_5, `EOF_K28_7};
  logic [7:0]  chval [0:3] = '{8'h03, 8'h01, 8'h02, 8'h05};
  logic [12:0] chexp [0:3] = '{{4'hF, 4'h7, 4'h4, 1'b0}, {4'h3, 4'h4, 4'h2, 1'b1},
                               {4'hC, 4'h4, 4'h2, 1'b1}, {4'h1, 4'h4, 4'h2, 1'b1}};

  serial_link_param_status_regs #(.LANES_FULL(LANES), .CONVERTERS_FULL(CONVS)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .link_st, .sync_pin_n,
    .spll_lock_pin, .cpll_lock_pin, .link_cfg, .chan_cfg, .irq);

  link_rx_model partner (.aclk, .aresetn, .link_cfg, .sysref_req, .realign_req, .mode_8b10b(mode),
                         .link_st, .sync_pin_n);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Every wait shares one bound so a stuck handshake ends the run
  task automatic step;
    @(posedge aclk);
    n++;
    if (n > 200) begin
      num_errors++;
      summarize();
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] val, input logic [1:0] exp);
    n = 0;
    // Idle edge first, so back-to-back calls never reassign bready in one step
    @(posedge aclk);
    awaddr  <= {2'h0, idx, 2'h0};
    wdata   <= {24'h0, val};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      step();
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do step(); while (!bvalid);
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, exp});
  endtask

  task automatic rd(input logic [11:0] idx);
    n = 0;
    @(posedge aclk);
    araddr  <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do step(); while (!arready);
    arvalid <= 1'b0;
    do step(); while (!rvalid);
    rready <= 1'b0;
    check("rdata upper", rdata & 32'hFFFFFF00, 32'h0);
    d  = rdata[7:0];
    rs = rresp;
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
    rd(idx);
    check("register", {24'h0, d}, {24'h0, exp});
    check("rresp", {30'h0, rs}, 32'h0);
  endtask

  task automatic pulse(input logic realign);
    if (realign) realign_req <= 1'b1;
    else sysref_req <= 1'b1;
    @(posedge aclk);
    realign_req <= 1'b0;
    sysref_req  <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  // End character insertion is checked every cycle while aresetn is high
  always @(posedge aclk) begin
    if (aresetn) check("eof_insert", {31'h0, link_cfg.eof_insert}, {31'h0, exp_ins});
    exp_ins <= aresetn && link_st.frame_end_slot && link_st.eight_b_ten_b_mode && link_cfg.link_enable;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sysref_req, realign_req} = '0;
    {spll_lock_pin, cpll_lock_pin, awaddr, araddr, wdata, wstrb, num_errors, tests_run, n} = '0;
    mode = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("link_cfg", 32'(link_cfg), 32'({1'b0, 8'h00, `EOF_K28_7, 1'b0}));
    check("chan_cfg", 32'(chan_cfg), {19'h0, 4'hF, 4'(LANES), 4'(CONVS), 1'b0});
    rd_chk(`IDX_STATUS, 8'h00);
    rd_chk(`IDX_CHANNEL, 8'h03);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wval, rows[i].resp);
      rd(rows[i].idx);
      check("row data", {24'h0, d}, {24'h0, rows[i].rval});
      check("row resp", {30'h0, rs}, {30'h0, rows[i].resp});
    end
    // Link stays disabled while identifier and character change
    for (int c = 0; c < 4; c++) begin
      wr(`IDX_FRAME_END, 8'(c), 2'h0);
      check("eof_char", {24'h0, link_cfg.eof_char}, {24'h0, kchar[c]});
    end
    wr(`IDX_DEVICE_NUMBER, 8'hA5, 2'h0);
    check("device_number", {24'h0, link_cfg.device_number}, 32'hA5);
    for (int c = 0; c < 4; c++) begin
      wr(`IDX_CHANNEL, chval[c], 2'h0);
      check("chan_cfg", 32'(chan_cfg), {19'h0, chexp[c]});
    end
    wr(`IDX_FRAME_END, 8'h00, 2'h0);
    spll_lock_pin <= 1'b1;
    cpll_lock_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    pulse(1'b0);
    rd_chk(`IDX_STATUS, 8'h05);
    wr(`IDX_IRQ_ENABLE, 8'h03, 2'h0);
    wr(`IDX_LINK_CTRL, 8'h01, 2'h0);
    check("link_enable", {31'h0, link_cfg.link_enable}, 32'h1);
    n = 0;
    do step(); while (!link_st.link_up);
    repeat (3) @(posedge aclk);
    pulse(1'b0);
    pulse(1'b1);
    rd_chk(`IDX_STATUS, 8'h7D);
    check("irq", {31'h0, irq}, 32'h1);
    rd_chk(`IDX_IRQ_STATUS, 8'h03);
    wr(`IDX_STATUS, 8'h18, 2'h0);
    rd_chk(`IDX_STATUS, 8'h65);
    wr(`IDX_IRQ_ENABLE, 8'h00, 2'h0);
    repeat (2) @(posedge aclk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(`IDX_IRQ_CLEAR, 8'h0F, 2'h0);
    rd_chk(`IDX_IRQ_STATUS, 8'h00);
    wr(`IDX_IRQ_ENABLE, 8'h08, 2'h0);
    spll_lock_pin <= 1'b0;
    mode <= 1'b0;
    repeat (4) @(posedge aclk);
    rd_chk(`IDX_STATUS, 8'h61);
    check("irq lock lost", {31'h0, irq}, 32'h1);
    wr(`IDX_LINK_CTRL, 8'h00, 2'h0);
    repeat (4) @(posedge aclk);
    rd_chk(`IDX_STATUS, 8'h01);
    rd_chk(`IDX_IRQ_STATUS, 8'h0C);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("irq reset", {31'h0, irq}, 32'h0);
    rd_chk(`IDX_DEVICE_NUMBER, 8'h00);
    rd_chk(`IDX_CHANNEL, 8'h03);
    summarize();
  end
endmodule

//--- verilog/serial_link_param_status_regs.sv
`timescale 1ns/100ps
`include "serial_link_regs_cfg.svh"
module serial_link_param_status_regs #(
  parameter int ADDR_W          = 16,
  parameter int LANES_FULL      = 8,
  parameter int CONVERTERS_FULL = 4
) (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  input  wire logic [ADDR_W-1:0]                    awaddr,
  input  wire logic                                 awvalid,
  output logic                                      awready,
  input  wire logic [31:0]                          wdata,
  input  wire logic [3:0]                           wstrb,
  input  wire logic                                 wvalid,
  output logic                                      wready,
  output logic [1:0]                                bresp,
  output logic                                      bvalid,
  input  wire logic                                 bready,
  input  wire logic [ADDR_W-1:0]                    araddr,
  input  wire logic                                 arvalid,
  output logic                                      arready,
  output logic [31:0]                               rdata,
  output logic [1:0]                                rresp,
  output logic                                      rvalid,
  input  wire logic                                 rready,
  input  wire serial_link_regs_pkg::link_status_type link_st,
  input  wire logic                                 sync_pin_n,
  input  wire logic                                 spll_lock_pin,
  input  wire logic                                 cpll_lock_pin,
  output serial_link_regs_pkg::link_cfg_type        link_cfg,
  output serial_link_regs_pkg::chan_cfg_type        chan_cfg,
  output logic                                      irq
);

  generate
    if (ADDR_W < 14 || LANES_FULL < 1 || LANES_FULL > 15 || CONVERTERS_FULL < 2 ||
        CONVERTERS_FULL > 15 || (CONVERTERS_FULL % 2) != 0) begin : bad_params
      $error("serial_link_param_status_regs: unsupported parameter values");
    end
  endgenerate

  localparam logic [3:0] LANES_ALL = 4'(LANES_FULL);
  localparam logic [3:0] LANES_HALF = 4'((LANES_FULL + 1) / 2);
  localparam logic [3:0] CONV_ALL = 4'(CONVERTERS_FULL);
  localparam logic [3:0] CONV_HALF = 4'(CONVERTERS_FULL / 2);
  localparam logic       LANES_ODD = 1'(LANES_FULL % 2);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d, w_strb0_q, w_strb0_d;
  logic [11:0] aw_idx_q, aw_idx_d;
  logic [7:0]  w_data_q, w_data_d;
  logic        awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic        arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr_fire;
  logic [7:0]  status_word;
  logic [7:0]  dev_q, chan_word;
  logic [1:0]  sel_q;
  logic [2:0]  chan_q;
  logic        link_en_q;
  logic [`IRQ_COUNT-1:0] irq_stat_q, irq_en_q;

  function automatic logic mapped(input logic [11:0] idx);
    mapped = idx >= `IDX_DEVICE_NUMBER && idx <= `IDX_IRQ_CLEAR;
  endfunction

  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign chan_word = {5'h00, chan_q};

  always_comb begin
    logic [11:0] rd_idx;
    rd_idx    = araddr[13:2];
    aw_have_d = aw_have_q;
    aw_idx_d  = aw_idx_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb0_d = w_strb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_idx_d  = awaddr[13:2];
    end
    if (wvalid && wready_q) begin
      w_have_d  = 1'b1;
      w_data_d  = wdata[7:0];
      w_strb0_d = wstrb[0];
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(aw_idx_q) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (rd_idx)  // Unused upper bits read zero
        `IDX_DEVICE_NUMBER: rdata_d = {24'h000000, dev_q};
        `IDX_FRAME_END:     rdata_d = {30'h00000000, sel_q};
        `IDX_STATUS:        rdata_d = {24'h000000, status_word};
        `IDX_CHANNEL:       rdata_d = {24'h000000, chan_word};
        `IDX_LINK_CTRL:     rdata_d = {31'h00000000, link_en_q};
        `IDX_IRQ_STATUS:    rdata_d = {28'h0000000, irq_stat_q};
        `IDX_IRQ_ENABLE:    rdata_d = {28'h0000000, irq_en_q};
        default:            rdata_d = 32'h00000000;
      endcase
    end
    // Hold off new requests while a response is still owed
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_idx_q  <= 12'h000;
      w_have_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_strb0_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      aw_idx_q  <= aw_idx_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_strb0_q <= w_strb0_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // ----------------------------------------
  // Registers, status and interrupts
  // ----------------------------------------
  logic [2:0]  sync1_q, sync2_q;
  logic [7:0]  dev_d, eof_char_q, eof_char_d;
  logic [1:0]  sel_d;
  logic [2:0]  chan_d;
  logic        link_en_d, link_en_prev_q, armed_q, armed_d;
  logic        realigned_q, realigned_d, multiframe_phase_set_flag_q, multiframe_phase_set_flag_d, multiframe_phase_set_flag_set;
  logic        eof_insert_q, eof_insert_d, link_up_prev_q, spll_prev_q, irq_q, irq_d, halved;
  logic        wr_status, wr_irq_clr;
  logic [`IRQ_COUNT-1:0] irq_stat_d, irq_en_d, events;
  serial_link_regs_pkg::chan_cfg_type chan_cfg_q, chan_cfg_d;

  // Pins are asynchronous to aclk; only sync2_q is read
  assign status_word = {1'b0, link_st.link_up, sync2_q[0], realigned_q, multiframe_phase_set_flag_q,
                        sync2_q[1], 1'b0, sync2_q[2]};
  assign wr_status   = wr_fire && w_strb0_q && aw_idx_q == `IDX_STATUS;
  assign wr_irq_clr  = wr_fire && w_strb0_q && aw_idx_q == `IDX_IRQ_CLEAR;
  assign multiframe_phase_set_flag_set = armed_q && link_st.sysref_event;
  assign events      = {spll_prev_q && !sync2_q[1], link_up_prev_q && !link_st.link_up,
                        multiframe_phase_set_flag_set, link_st.sysref_realign};

  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_COUNT; gi++) begin : irq_bits
      // New event outranks a clear in the same cycle
      assign irq_stat_d[gi] = events[gi] || (irq_stat_q[gi] && !(wr_irq_clr && w_data_q[gi]));
    end
  endgenerate

  always_comb begin
    dev_d     = dev_q;
    sel_d     = sel_q;
    chan_d    = chan_q;
    link_en_d = link_en_q;
    irq_en_d  = irq_en_q;
    if (wr_fire && w_strb0_q) begin
      unique case (aw_idx_q)
        `IDX_DEVICE_NUMBER: dev_d = w_data_q;
        `IDX_FRAME_END:     sel_d = w_data_q[1:0];
        `IDX_CHANNEL:       chan_d = w_data_q[2:0];
        `IDX_LINK_CTRL:     link_en_d = w_data_q[0];
        `IDX_IRQ_ENABLE:    irq_en_d = w_data_q[`IRQ_COUNT-1:0];
        default:            ;
      endcase
    end
    // Set wins over write-1-clear
    realigned_d = link_st.sysref_realign || (realigned_q && !(wr_status && w_data_q[`ST_REALIGNED]));
    multiframe_phase_set_flag_d   = multiframe_phase_set_flag_set || (multiframe_phase_set_flag_q && !(wr_status && w_data_q[`ST_MULTIFRAME_PHASE_SET_FLAG]));
    if (!link_en_q || link_st.sysref_event) begin
      armed_d = 1'b0;
    end else if (!link_en_prev_q) begin
      armed_d = 1'b1;
    end else begin
      armed_d = armed_q;
    end
    unique case (sel_d)  // Reserved code 3 falls back to K28.7
      `EOF_SEL_K28_1: eof_char_d = `EOF_K28_1;
      `EOF_SEL_K28_5: eof_char_d = `EOF_K28_5;
      default:        eof_char_d = `EOF_K28_7;
    endcase
    eof_insert_d = link_en_q && link_st.eight_b_ten_b_mode && link_st.frame_end_slot;
    halved = !(chan_d[`CH_LOWER] && chan_d[`CH_UPPER]) || chan_d[`CH_SINGLE];
    chan_cfg_d.channel_enable  = chan_d[`CH_SINGLE] ? 4'h1 :
                                 {{2{chan_d[`CH_UPPER]}}, {2{chan_d[`CH_LOWER]}}};
    chan_cfg_d.lanes_used      = halved ? LANES_HALF : LANES_ALL;
    chan_cfg_d.converters_used = halved ? CONV_HALF : CONV_ALL;
    chan_cfg_d.tail_pad        = halved && LANES_ODD;
    irq_d = |(irq_stat_d & irq_en_d);
  end

  always_ff @(posedge aclk) begin
    sync1_q <= {cpll_lock_pin, spll_lock_pin, sync_pin_n};
    sync2_q <= sync1_q;
    if (!aresetn) begin
      dev_q          <= `RST_DEVICE_NUMBER;
      sel_q          <= `RST_FRAME_END;
      chan_q         <= `RST_CHANNEL;
      link_en_q      <= 1'b0;
      link_en_prev_q <= 1'b0;
      armed_q        <= 1'b0;
      irq_en_q       <= '0;
      irq_stat_q     <= '0;
      realigned_q    <= 1'b0;
      multiframe_phase_set_flag_q      <= 1'b0;
      eof_char_q     <= `EOF_K28_7;
      eof_insert_q   <= 1'b0;
      link_up_prev_q <= 1'b0;
      spll_prev_q    <= 1'b0;
      chan_cfg_q     <= {4'hF, LANES_ALL, CONV_ALL, 1'b0};
      irq_q          <= 1'b0;
    end else begin
      dev_q          <= dev_d;
      sel_q          <= sel_d;
      chan_q         <= chan_d;
      link_en_q      <= link_en_d;
      link_en_prev_q <= link_en_q;
      armed_q        <= armed_d;
      irq_en_q       <= irq_en_d;
      irq_stat_q     <= irq_stat_d;
      realigned_q    <= realigned_d;
      multiframe_phase_set_flag_q      <= multiframe_phase_set_flag_d;
      eof_char_q     <= eof_char_d;
      eof_insert_q   <= eof_insert_d;
      link_up_prev_q <= link_st.link_up;
      spll_prev_q    <= sync2_q[1];
      chan_cfg_q     <= chan_cfg_d;
      irq_q          <= irq_d;
    end
  end

  assign link_cfg = {link_en_q, dev_q, eof_char_q, eof_insert_q};
  assign chan_cfg = chan_cfg_q;
  assign irq      = irq_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence dev_write_s;
    wr_fire && w_strb0_q && aw_idx_q == `IDX_DEVICE_NUMBER;
  endsequence
  sequence status_read_s;
    arvalid && arready_q && araddr[13:2] == `IDX_STATUS;
  endsequence

  device_number_a: assert property (dev_write_s |=> link_cfg.device_number == $past(w_data_q))
    else $error("device number not taken from write");
  eof_code_a: assert property (sel_q == `EOF_SEL_K28_5 |-> link_cfg.eof_char == `EOF_K28_5)
    else $error("end character does not follow select");
  eof_mode_a: assert property (!link_st.eight_b_ten_b_mode |=> !link_cfg.eof_insert)
    else $error("end character inserted outside 8B/10B");
  link_up_a: assert property (status_read_s |=> rdata[`ST_LINK_UP] == $past(link_st.link_up))
    else $error("link up bit wrong");
  sync_level_a: assert property (sync_pin_n [*3] ##0 status_read_s |=> rdata[`ST_SYNC])
    else $error("sync status bit wrong");
  realign_set_a: assert property (link_st.sysref_realign |=> realigned_q [*2] or (realigned_q ##1 1'b1))
    else $error("realign flag not set");
  multiframe_phase_set_flag_first_a: assert property ($rose(multiframe_phase_set_flag_q) |-> $past(multiframe_phase_set_flag_set))
    else $error("multiframe_phase_set_flag flag set without first sysref");
  spll_lock_a: assert property (!spll_lock_pin [*3] ##0 status_read_s |=> !rdata[`ST_SPLL])
    else $error("serializer lock bit wrong");
  cpll_lock_a: assert property (cpll_lock_pin [*3] ##0 status_read_s |=> rdata[`ST_CPLL])
    else $error("converter lock bit wrong");
  single_chan_a: assert property (chan_q[`CH_SINGLE] |-> chan_cfg.channel_enable == 4'h1)
    else $error("single channel not applied");
  lane_halve_a: assert property (!chan_q[`CH_UPPER] |-> chan_cfg.lanes_used == LANES_HALF)
    else $error("lane count not halved");
  reserved_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("reserved read bits not zero");

endmodule

//--- verilog/serial_link_regs_cfg.svh
`ifndef SERIAL_LINK_REGS_CFG_SVH
`define SERIAL_LINK_REGS_CFG_SVH

// ----------------------------------------
// Register indices, byte address is index * 4
// ----------------------------------------
`define IDX_DEVICE_NUMBER 12'h206
`define IDX_FRAME_END     12'h207
`define IDX_STATUS        12'h208
`define IDX_CHANNEL       12'h209
`define IDX_LINK_CTRL     12'h20A
`define IDX_IRQ_STATUS    12'h20B
`define IDX_IRQ_ENABLE    12'h20C
`define IDX_IRQ_CLEAR     12'h20D

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ST_LINK_UP   6
`define ST_SYNC      5
`define ST_REALIGNED 4
`define ST_MULTIFRAME_PHASE_SET_FLAG   3
`define ST_SPLL      2
`define ST_CPLL      0
`define CH_SINGLE    2
`define CH_UPPER     1
`define CH_LOWER     0
`define IRQ_COUNT    4

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RST_DEVICE_NUMBER 8'h00
`define RST_FRAME_END     2'h0
`define RST_CHANNEL       3'h3
`define EOF_SEL_K28_1     2'h1
`define EOF_SEL_K28_5     2'h2
`define EOF_K28_7         8'hFC
`define EOF_K28_1         8'h3C
`define EOF_K28_5         8'hBC
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

//--- verilog/serial_link_regs_pkg.sv
package serial_link_regs_pkg;

  typedef struct packed {
    logic link_up;
    logic sysref_realign;
    logic sysref_event;
    logic frame_end_slot;
    logic eight_b_ten_b_mode;
  } link_status_type;

  typedef struct packed {
    logic       link_enable;
    logic [7:0] device_number;
    logic [7:0] eof_char;
    logic       eof_insert;
  } link_cfg_type;

  typedef struct packed {
    logic [3:0] channel_enable;
    logic [3:0] lanes_used;
    logic [3:0] converters_used;
    logic       tail_pad;
  } chan_cfg_type;

endpackage
